// file: dv/asx_remote.sv
// Remote serial device: frame decoder on the line, break source on receive
`timescale 1ns/1ps
module asx_remote #(
  parameter int BP = 4 // Bit period in clocks
) (
  input  wire logic clk_i,  // Clock
  input  wire logic txd_i,  // Line from transmitter
  input  wire logic inv_i,  // Line inverted
  input  wire logic nine_i, // Nine data bits
  input  wire logic en_i,   // Decoder armed
  output logic       rxd_o,  // Line to receiver
  output logic       got_o,  // One-cycle frame strobe
  output logic [9:0] word_o, // Stop, ninth, data
  output logic [9:0] run_o   // Clocks until line released
);
  logic [9:0] w; // Word under assembly
  int         r; // Clocks since start seen
  initial begin
    rxd_o = 1'b1;
    got_o = 1'b0;
    word_o = 10'h0;
    run_o = 10'h0;
  end
  // Low for whole bit periods; rises again after
  task automatic send_brk(input int n);
    rxd_o <= 1'b0;
    repeat (n * BP) @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask
  always begin
    @(posedge clk_i);
    got_o <= 1'b0;
    if (en_i === 1'b1 && (txd_i ^ inv_i) === 1'b0) begin
      r = BP / 2;
      w = 10'h0;
      repeat (BP / 2) @(posedge clk_i);
      for (int i = 0; i < (nine_i ? 10 : 9); i++) begin
        repeat (BP) @(posedge clk_i);
        r += BP;
        w[i] = txd_i ^ inv_i;
      end
      // Stop always lands in the top bit
      if (!nine_i) begin
        w[9] = w[8];
        w[8] = 1'b0;
      end
      while ((txd_i ^ inv_i) !== 1'b1) begin
        @(posedge clk_i);
        r++;
      end
      word_o <= w;
      run_o <= 10'(r);
      got_o <= 1'b1;
    end
  end
endmodule // asx_remote

// file: dv/asx_sva.sv
// Checker of the serial transmitter bus handshake and pin ownership
`timescale 1ns/1ps
module asx_sva (
  input wire logic        clk_i,    // Clock
  input wire logic        rst_i,    // Reset, high
  input wire logic        wb_cyc_i, // Bus cycle
  input wire logic        wb_stb_i, // Bus strobe
  input wire logic        wb_we_i,  // Write enable
  input wire logic [7:0]  wb_adr_i, // Byte address
  input wire logic [3:0]  wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic        wb_ack_o, // Acknowledge
  input wire logic        rxd_i,    // Receive pin
  input wire logic        txd_o,    // Transmit pin
  input wire logic        txd_oe_o, // Pin owned
  input wire logic        irq_o     // Interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_c1; // Control-one write taking effect
  assign wr_c1 = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00;
  // Ack is a single pulse, one cycle after the request
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  // Unused read bits and holes read zero
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1c |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
  pin_claim_a: assert property (wr_c1 && wb_dat_i[7] |-> ##[1:3] txd_oe_o) else $error("pin not claimed");
  pin_release_a: assert property (wr_c1 && !wb_dat_i[7] |-> ##[1:3] !txd_oe_o) else $error("pin kept");
  reset_idle_a: assert property ($fell(rst_i) |-> txd_o && !txd_oe_o && !irq_o) else $error("not idle");
  cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h14);
  cover property ($rose(txd_oe_o));
  cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 && wb_dat_o[1]);
endmodule // asx_sva

bind asx_top asx_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .rxd_i(rxd_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .irq_o(irq_o)
);

// file: dv/tb_top.sv
// Self-checking bench of the serial transmitter
`timescale 1ns/1ps
module tb_top;
  localparam int BP = 4; // Bit period: divisor 4, fast source
  logic        clk_i = 1'b0;  // Clock
  logic        rst_i = 1'b1;  // Reset
  logic        cyc   = 1'b0;  // Cycle and strobe
  logic        we    = 1'b0;  // Direction
  logic [7:0]  adr   = 8'h00; // Address
  logic [31:0] dat   = 32'h0; // Write data
  logic        rinv  = 1'b0;  // Remote inverts
  logic        rnine = 1'b0;  // Remote nine bits
  logic        ren   = 1'b0;  // Remote armed
  logic [31:0] dout, rd;      // Read data
  logic        ack, txd, oe, irq, rxd, got; // Pins
  logic [9:0]  word, run;     // Remote frame
  logic [19:0] e;             // Expected entry
  logic [19:0] expq[$];       // Model: run, stop, ninth, data
  int          fails = 0, checks_done = 0, cnt = 0, t0 = 0, tg = 0, tp = 0; // Counters

  asx_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .rxd_i(rxd), .txd_o(txd),
    .txd_oe_o(oe), .irq_o(irq));
  asx_remote #(.BP(BP)) u_rem (.clk_i(clk_i), .txd_i(txd), .inv_i(rinv), .nine_i(rnine), .en_i(ren),
    .rxd_o(rxd), .got_o(got), .word_o(word), .run_o(run));

  always #50 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Classic cycle: hold until ack, then drop for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dout;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, rd, x);
  endtask

  // status read before each data write
  task automatic send(input logic [7:0] v, input logic b8, input logic nine);
    do bus(1'b0, 8'h0c, 8'h00); while (rd[7] !== 1'b1);
    bus(1'b1, 8'h08, {1'b0, b8, 6'h0});
    bus(1'b1, 8'h14, v);
    expq.push_back({10'h0, 1'b1, nine & b8, v});
  endtask

  task automatic wait_done();
    do bus(1'b0, 8'h0c, 8'h00); while (rd[6] !== 1'b1);
  endtask

  // Every remote frame against the model; hang guard
  always @(posedge clk_i) begin
    cnt++;
    if (cnt > 20000) begin
      fails++;
      wrap_up();
    end else if (got === 1'b1) begin
      tp = tg;
      tg = cnt;
      e = (expq.size() > 0) ? expq.pop_front() : 20'hfffff;
      chk("frame", {22'h0, word}, {22'h0, e[9:0]});
      if (e[19:10] != 10'h0) chk("brk_len", {22'h0, run}, {22'h0, e[19:10]});
    end
  end

  initial begin
    void'($urandom(32'h364a));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("txd_rst", {31'h0, txd}, 32'h1);
    rchk(8'h0c, 32'hc0, "stat_one_rst");
    rchk(8'h18, 32'h03, "baud_rst");
    rchk(8'h1c, 32'h01, "option_rst");
    rchk(8'h20, 32'h0, "unmapped");
    bus(1'b1, 8'h1c, 8'h00);
    bus(1'b1, 8'h14, 8'h5a);
    rchk(8'h14, 32'h0, "data_wo");
    bus(1'b1, 8'h00, 8'h80);
    ren <= 1'b1;
    t0 = cnt;
    bus(1'b1, 8'h04, 8'h08);
    chk("oe_on", {31'h0, oe}, 32'h1);
    send(8'ha5, 1'b0, 1'b0);
    wait_done();
    chk("preamble", {31'h0, (tg - t0) >= 19 * BP}, 32'h1);
    // Plain, nine-bit, inverted, plain again
    for (int m = 0; m < 4; m++) begin
      ren <= 1'b0;
      bus(1'b1, 8'h00, 8'h80 | (m == 1 ? 8'h10 : 8'h00) | (m == 2 ? 8'h01 : 8'h00));
      if (m == 3) begin
        // Bus-rate source with divisor one keeps the same bit period
        bus(1'b1, 8'h1c, 8'h01);
        bus(1'b1, 8'h18, 8'h00);
      end
      repeat (4) @(posedge clk_i);
      rinv <= (m == 2);
      rnine <= (m == 1);
      ren <= 1'b1;
      repeat (3) send(8'($urandom), 1'($urandom), m == 1);
      wait_done();
    end
    bus(1'b1, 8'h1c, 8'h00);
    bus(1'b1, 8'h18, 8'h03);
    bus(1'b1, 8'h04, 8'h88);
    @(posedge clk_i);
    chk("irq_empty", {31'h0, irq}, 32'h1);
    send(8'h3c, 1'b0, 1'b0);
    send(8'hc3, 1'b0, 1'b0);
    @(posedge clk_i);
    chk("irq_full", {31'h0, irq}, 32'h0);
    bus(1'b1, 8'h04, 8'h48);
    @(posedge clk_i);
    chk("irq_busy", {31'h0, irq}, 32'h0);
    wait_done();
    chk("irq_done", {31'h0, irq}, 32'h1);
    // Single breaks: short, long select, nine-bit
    for (int b = 0; b < 3; b++) begin
      bus(1'b1, 8'h00, b == 2 ? 8'h90 : 8'h80);
      rnine <= (b == 2);
      bus(1'b1, 8'h18, b == 1 ? 8'h43 : 8'h03);
      expq.push_back({10'(BP * (10 + (b > 0))), 10'h000});
      bus(1'b1, 8'h04, 8'h09);
      repeat (2 * BP) @(posedge clk_i);
      bus(1'b1, 8'h04, 8'h08);
      send(8'h0f, 1'b0, b == 2);
      wait_done();
    end
    bus(1'b1, 8'h00, 8'h80);
    rnine <= 1'b0;
    bus(1'b1, 8'h18, 8'h03);
    // Drop and restore the transmitter mid-frame
    send(8'h96, 1'b0, 1'b0);
    repeat (3 * BP) @(posedge clk_i);
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b1, 8'h04, 8'h08);
    send(8'h69, 1'b0, 1'b0);
    wait_done();
    chk("idle_gap", {31'h0, (tg - tp) >= 20 * BP}, 32'h1);
    // Short: nine zeros none, twelve break; long: ten none, eleven break
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 8'h18, k > 1 ? 8'h43 : 8'h03);
      u_rem.send_brk(k == 0 ? 9 : (k == 1 ? 12 : (k == 2 ? 10 : 11)));
      repeat (BP) @(posedge clk_i);
      bus(1'b0, 8'h0c, 8'h00);
      chk("rx_brk", {30'h0, rd[5], rd[1]}, (k % 2) ? 32'h3 : 32'h0);
      bus(1'b1, 8'h0c, 8'h22);
    end
    rchk(8'h10, 32'h02, "brk_flag");
    rchk(8'h14, 32'h0, "rx_data");
    bus(1'b1, 8'h00, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("oe_off", {31'h0, oe}, 32'h0);
    chk("pending", 32'(expq.size()), 32'h0);
    wrap_up();
  end
endmodule // tb_top

// file: hdl/asx_baud.sv
// Shared baud generator: selects the clock source and divides it to bit ticks
`timescale 1ns/1ps
`include "asx_params.svh"
module asx_baud
  import asx_pkg::*;
(
  input  wire logic       clk_i,      // Reference clock
  input  wire logic       rst_i,      // Synchronous reset, high
  input  wire logic       src_bus_i,  // 1: bus clock rate, 0: 4x rate
  input  wire logic [5:0] div_i,      // Divisor minus one
  output logic            tick_o      // One-cycle bit tick
);
  logic [1:0] pre_q;  // Bus-rate prescaler
  logic [5:0] cnt_q;  // Divisor counter
  logic       src_en; // Source clock enable

  // Source strobe: every cycle for 4x, one in four for bus rate
  assign src_en = src_bus_i ? (pre_q == `ASX_BUS_DIV) : 1'b1;

  // Prescaler free-runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 2'h0;
    end else begin
      pre_q <= pre_q + 2'h1;
    end
  end

  // Divider; tick is registered so it is glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= 6'h00;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (src_en) begin
        if (cnt_q >= div_i) begin
          cnt_q  <= 6'h00;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 6'h01;
        end
      end
    end
  end
endmodule // asx_baud

// file: hdl/asx_params.svh
// Offsets, field positions, reset values and timing counts of the serial transmitter
`ifndef ASX_PARAMS_SVH
`define ASX_PARAMS_SVH
// Register byte offsets on the bus
`define ASX_OFF_CTRL_ONE   8'h00
`define ASX_OFF_CTRL_TWO   8'h04
`define ASX_OFF_CTRL_THREE 8'h08
`define ASX_OFF_STAT_ONE   8'h0c
`define ASX_OFF_STAT_TWO   8'h10
`define ASX_OFF_DATA       8'h14
`define ASX_OFF_BAUD       8'h18
`define ASX_OFF_OPTION     8'h1c
// ser_ctrl_one fields
`define ASX_C1_SERIAL_ON   7
`define ASX_C1_NINE_BIT    4
`define ASX_C1_POL_FLIP    0
// ser_ctrl_two fields
`define ASX_C2_EMPTY_IE    7
`define ASX_C2_DONE_IE     6
`define ASX_C2_TX_ON       3
`define ASX_C2_SEND_BRK    0
// ser_ctrl_three fields
`define ASX_C3_RX_NINTH    7
`define ASX_C3_TX_NINTH    6
// ser_stat_one fields
`define ASX_S1_TX_EMPTY    7
`define ASX_S1_TX_DONE     6
`define ASX_S1_RX_FULL     5
`define ASX_S1_FRAME_ERR   1
// ser_stat_two fields
`define ASX_S2_BRK         1
// baud_reg fields: divisor in [5:0], long break select in bit 6
`define ASX_BR_LONG_BRK    6
// option_reg_two fields
`define ASX_OPT_BAUD_SRC   0
// Reset values
`define ASX_RST_BAUD       8'h03
`define ASX_RST_OPTION     8'h01
// Bus clock is the reference divided by four
`define ASX_BUS_DIV        2'h3
`endif

// file: hdl/asx_pkg.sv
// Types shared by the serial transmitter files
package asx_pkg;
  // Transmit machine states
  typedef enum logic [0:0] {
    ASX_TX_IDLE,
    ASX_TX_SHIFT
  } asx_tx_state_t;
endpackage

// file: hdl/asx_top.sv
// Asynchronous serial transmitter with break recognition and a Wishbone slave
//
// Function
// - Send 8-bit or 9-bit characters
// - Data register is write-only transmit buffer
// - Preamble idle character precedes first data
// - Start bit zero, stop bit one, LSB first
// - Empty flag sets on transfer, may interrupt
// - Line idles at logic one
// - Clearing serial enable releases the pin
// - Send-break writes load all-zero break
// - Break length follows length and long-break
// - Breaks repeat; a one bit follows
// - Short mode: 10 or 11 zeros break
// - Long mode: 11 or 12 zeros break
// - Break sets flags, clears receive data
// - Idle character is all ones
// - Disabling transmitter finishes current character
// - Re-enable mid-frame queues one idle
// - Option bit selects baud clock source
// - One baud generator shared by both
// - Polarity flip inverts every transmitted level
// - Done flag when everything is empty
`timescale 1ns/1ps
`include "asx_params.svh"
module asx_top
  import asx_pkg::*;
(
  input  wire logic        clk_i,     // 10 MHz clock
  input  wire logic        rst_i,     // Synchronous reset, high
  input  wire logic        wb_cyc_i,  // Bus cycle
  input  wire logic        wb_stb_i,  // Bus strobe
  input  wire logic        wb_we_i,   // Write enable
  input  wire logic [7:0]  wb_adr_i,  // Byte address
  input  wire logic [3:0]  wb_sel_i,  // Byte lanes
  input  wire logic [31:0] wb_dat_i,  // Write data
  output logic      [31:0] wb_dat_o,  // Read data
  output logic             wb_ack_o,  // Acknowledge
  input  wire logic        rxd_i,     // Receive pin level
  output logic             txd_o,     // Transmit pin level
  output logic             txd_oe_o,  // Transmit pin owned by us
  output logic             irq_o      // Transmitter interrupt request
);
  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0]    ctrl_one_q;    // ser_ctrl_one
  logic [7:0]    ctrl_two_q;    // ser_ctrl_two
  logic          tx_ninth_q;    // tx_ninth_bit
  logic          rx_ninth_q;    // rx_ninth_bit
  logic [7:0]    baud_q;        // baud_reg
  logic [7:0]    option_q;      // option_reg_two
  logic [7:0]    hold_q;        // Transmit holding buffer
  logic          hold_nine_q;   // Ninth bit captured with data
  logic          hold_full_q;   // Holding buffer occupied
  logic [7:0]    rx_data_q;     // Receive data register
  logic          rx_full_q;     // rx_full_flag
  logic          frame_err_q;   // framing_error_flag
  logic          brk_flag_q;    // brk_flag
  logic          done_q;        // tx_done_flag
  asx_tx_state_t state_q;       // Transmit machine state
  logic [11:0]   shift_q;       // Transmit shift register
  logic [3:0]    left_q;        // Bits left to shift
  logic          idle_pend_q;   // Idle character queued
  logic          one_pend_q;    // Trailing one after break
  logic          tx_on_d1_q;    // Previous tx_on_bit
  logic [3:0]    zero_cnt_q;    // Consecutive received zeros
  logic          brk_seen_q;    // Break already reported
  logic          tick;          // Shared bit tick
  logic          wr_acc;        // Write takes effect
  logic          idle_req;      // Idle character wanted now
  logic          serial_on;     // serial_on_bit
  logic          nine;          // Nine-bit character mode
  logic          tx_on;         // tx_on_bit
  logic          send_brk;      // send_brk_bit
  logic          long_brk;      // long_brk_sel
  logic          load_data;     // Data moves into shifter
  logic          brk_hit;       // Break recognised this tick
  logic [7:0]    stat_one;      // Status one image
  logic [7:0]    rd_mux;        // Read data select

  assign serial_on = ctrl_one_q[`ASX_C1_SERIAL_ON];
  assign nine      = ctrl_one_q[`ASX_C1_NINE_BIT];
  assign tx_on     = ctrl_two_q[`ASX_C2_TX_ON];
  assign send_brk  = ctrl_two_q[`ASX_C2_SEND_BRK];
  assign long_brk  = baud_q[`ASX_BR_LONG_BRK];

  // Character length in bits: start, data, stop
  function automatic logic [3:0] frame_len(input logic nine_bit);
    frame_len = nine_bit ? 4'd11 : 4'd10;
  endfunction

  // Write to a given register on lane zero
  function automatic logic hit(input logic [7:0] off);
    hit = (wb_adr_i == off) && wb_sel_i[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  // Access acts on the edge the master samples ack
  assign wr_acc = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

  // One wait state; ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Status one image
  assign stat_one = {!hold_full_q, done_q, rx_full_q, 3'h0, frame_err_q, 1'b0};

  // Read mux; unmapped offsets read zero
  always_comb begin
    case (wb_adr_i)
      `ASX_OFF_CTRL_ONE:   rd_mux = ctrl_one_q;
      `ASX_OFF_CTRL_TWO:   rd_mux = ctrl_two_q;
      `ASX_OFF_CTRL_THREE: rd_mux = {rx_ninth_q, tx_ninth_q, 6'h00};
      `ASX_OFF_STAT_ONE:   rd_mux = stat_one;
      `ASX_OFF_STAT_TWO:   rd_mux = {6'h00, brk_flag_q, 1'b0};
      // Transmit side is write-only; reads see receive data
      `ASX_OFF_DATA:       rd_mux = rx_data_q;
      `ASX_OFF_BAUD:       rd_mux = baud_q;
      `ASX_OFF_OPTION:     rd_mux = option_q;
      default:             rd_mux = 8'h00;
    endcase
  end

  // Read data captured while ack rises
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Plain read/write control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_q <= 8'h00;
      ctrl_two_q <= 8'h00;
      tx_ninth_q <= 1'b0;
      baud_q     <= `ASX_RST_BAUD;
      option_q   <= `ASX_RST_OPTION;
    end else if (wr_acc) begin
      if (hit(`ASX_OFF_CTRL_ONE)) begin
        ctrl_one_q <= wb_dat_i[7:0];
      end
      if (hit(`ASX_OFF_CTRL_TWO)) begin
        ctrl_two_q <= wb_dat_i[7:0];
      end
      if (hit(`ASX_OFF_CTRL_THREE)) begin
        tx_ninth_q <= wb_dat_i[`ASX_C3_TX_NINTH];
      end
      if (hit(`ASX_OFF_BAUD)) begin
        baud_q <= wb_dat_i[7:0];
      end
      if (hit(`ASX_OFF_OPTION)) begin
        option_q <= wb_dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generator

  // Source select; one generator for both directions
  asx_baud u_baud (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .src_bus_i (option_q[`ASX_OPT_BAUD_SRC]),
    .div_i     (baud_q[5:0]),
    .tick_o    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding buffer

  // An enable edge counts as queued at once, so held data never jumps the preamble
  assign idle_req = idle_pend_q || (tx_on && !tx_on_d1_q);

  // Data leaves the buffer when the shifter takes it
  assign load_data = tick && serial_on && tx_on && (state_q == ASX_TX_IDLE || left_q == 4'd1)
                     && !idle_req && !send_brk && !one_pend_q && hold_full_q;

  // Write-only buffer; empty sets on transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_full_q <= 1'b0;
      hold_q      <= 8'h00;
      hold_nine_q <= 1'b0;
    end else if (wr_acc && hit(`ASX_OFF_DATA)) begin
      // Data write clears the empty flag
      hold_full_q <= 1'b1;
      hold_q      <= wb_dat_i[7:0];
      hold_nine_q <= tx_ninth_q;
    end else if (load_data || !serial_on) begin
      hold_full_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit machine

  // Shifter loads on a tick when idle or on the last bit
  always_ff @(posedge clk_i) begin
    if (rst_i || !serial_on) begin
      state_q     <= ASX_TX_IDLE;
      shift_q     <= 12'hfff;
      left_q      <= 4'd0;
      idle_pend_q <= 1'b0;
      one_pend_q  <= 1'b0;
      tx_on_d1_q  <= 1'b0;
    end else begin
      tx_on_d1_q <= tx_on;
      // Enable edge queues the preamble; also mid-frame
      if (tx_on && !tx_on_d1_q) begin
        idle_pend_q <= 1'b1;
      end
      if (tick) begin
        if (state_q == ASX_TX_SHIFT && left_q != 4'd1) begin
          shift_q <= {1'b1, shift_q[11:1]};
          left_q  <= left_q - 4'd1;
        end else if (!tx_on) begin
          state_q <= ASX_TX_IDLE;
          shift_q <= 12'hfff;
          left_q  <= 4'd0;
        end else if (idle_req) begin
          state_q     <= ASX_TX_SHIFT;
          shift_q     <= 12'hfff;
          left_q      <= frame_len(nine);
          idle_pend_q <= 1'b0;
        end else if (send_brk) begin
          state_q    <= ASX_TX_SHIFT;
          shift_q    <= 12'h000;
          left_q     <= frame_len(nine) + {3'h0, long_brk};
          one_pend_q <= 1'b1;
        end else if (one_pend_q) begin
          // At least one bit of one after a break
          state_q    <= ASX_TX_SHIFT;
          shift_q    <= 12'hfff;
          left_q     <= 4'd1;
          one_pend_q <= 1'b0;
        end else if (hold_full_q) begin
          // Start zero low, stop one high; ninth bit
          state_q <= ASX_TX_SHIFT;
          shift_q <= nine ? {1'b1, 1'b1, hold_nine_q, hold_q, 1'b0}
                          : {1'b1, 1'b1, 1'b1, hold_q, 1'b0};
          left_q  <= frame_len(nine);
        end else begin
          state_q <= ASX_TX_IDLE;
          shift_q <= 12'hfff;
          left_q  <= 4'd0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin and flags

  // Pin driven from a flop; a level while shifting, else idle one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_o    <= 1'b1;
      txd_oe_o <= 1'b0;
    end else begin
      // Flip every level; idle is one before flipping
      txd_o <= ((state_q == ASX_TX_SHIFT) ? shift_q[0] : 1'b1)
               ^ ctrl_one_q[`ASX_C1_POL_FLIP];
      // Pin handed back to the port when disabled
      txd_oe_o <= serial_on;
    end
  end

  // Done when shifter, buffer and queue are all empty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b1;
    end else begin
      done_q <= state_q == ASX_TX_IDLE && !hold_full_q && !idle_pend_q
                && !one_pend_q && !send_brk;
    end
  end

  // Empty and done requests, each gated by its enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (!hold_full_q && ctrl_two_q[`ASX_C2_EMPTY_IE])
               || (done_q && ctrl_two_q[`ASX_C2_DONE_IE]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received break recognition
  // Samples once per bit tick; not a full data recovery path, so the
  // count is only exact when the far end shares the bit rate.

  // Short mode count; long mode adds one
  assign brk_hit = tick && serial_on && !rxd_i && !brk_seen_q
                   && (zero_cnt_q + 4'd1 == frame_len(nine) + {3'h0, long_brk});

  // Count consecutive zeros, report once per break
  always_ff @(posedge clk_i) begin
    if (rst_i || !serial_on) begin
      zero_cnt_q <= 4'd0;
      brk_seen_q <= 1'b0;
    end else if (tick) begin
      if (rxd_i) begin
        zero_cnt_q <= 4'd0;
        brk_seen_q <= 1'b0;
      end else if (brk_hit) begin
        brk_seen_q <= 1'b1;
      end else if (!brk_seen_q) begin
        zero_cnt_q <= zero_cnt_q + 4'd1;
      end
    end
  end

  // Break sets flags and clears data; set beats write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_full_q   <= 1'b0;
      frame_err_q <= 1'b0;
      brk_flag_q  <= 1'b0;
      rx_data_q   <= 8'h00;
      rx_ninth_q  <= 1'b0;
    end else if (brk_hit) begin
      rx_full_q   <= 1'b1;
      frame_err_q <= 1'b1;
      brk_flag_q  <= 1'b1;
      rx_data_q   <= 8'h00;
      rx_ninth_q  <= 1'b0;
    end else if (wr_acc) begin
      if (hit(`ASX_OFF_STAT_ONE) && wb_dat_i[`ASX_S1_RX_FULL]) begin
        rx_full_q <= 1'b0;
      end
      if (hit(`ASX_OFF_STAT_ONE) && wb_dat_i[`ASX_S1_FRAME_ERR]) begin
        frame_err_q <= 1'b0;
      end
      if (hit(`ASX_OFF_STAT_TWO) && wb_dat_i[`ASX_S2_BRK]) begin
        brk_flag_q <= 1'b0;
      end
    end
  end
endmodule // asx_top
